// file: inc/chg_ctrl_pkg.sv
// Constants and types shared by the charger pulse-program control logic.
package chg_ctrl_pkg;

    // Clock rate in kHz, used to turn times into cycle counts.
    localparam int unsigned CLK_KHZ = 100000;

    // Times in microseconds, as specified.
    localparam int unsigned PROGRAM_LOCK_US = 4000;
    localparam int unsigned SHUTDOWN_DELAY_US = 4000;
    localparam int unsigned DEBOUNCE_US = 2000;
    localparam int unsigned RAMP_US = 250;

    // Cycle counts derived from the times (least times round up).
    localparam int unsigned LOCK_CYCLES =
        (PROGRAM_LOCK_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned SHUTDOWN_CYCLES =
        (SHUTDOWN_DELAY_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned DEBOUNCE_CYCLES =
        (DEBOUNCE_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned RAMP_CYCLES = (RAMP_US * CLK_KHZ + 999) / 1000;

    // Width of the ramp level output and number of ramp steps per change.
    localparam int unsigned LEVEL_W = 8;
    localparam logic [LEVEL_W-1:0] LEVEL_FULL = 8'hff;

    // Pulse counter width; it saturates so four or more stays four.
    localparam int unsigned PCNT_W = 3;
    localparam logic [PCNT_W-1:0] PCNT_SAT = 3'h4;

    // Fast-charge current selections.
    typedef enum logic [1:0] {
        SEL_DEFAULT_400 = 2'h0,
        SEL_RESISTOR = 2'h1,
        SEL_LOW_90 = 2'h2,
        SEL_RF_TEST = 2'h3
    } current_sel_t;

    // Charger control states, one-hot.
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_DEBOUNCE = 4'h2,
        ST_CHARGE = 4'h4,
        ST_TOPOFF = 4'h8
    } chg_state_t;

    // Interrupt status bit positions.
    localparam int unsigned IRQ_LOCKED = 0;
    localparam int unsigned IRQ_TOPOFF = 1;
    localparam int unsigned IRQ_DISABLED = 2;
    localparam int unsigned IRQ_PWR_FAIL = 3;
    localparam int unsigned IRQ_W = 4;

    // Register offsets and the mask reset value.
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h4;
    localparam logic [3:0] REG_IRQ_MASK = 4'h8;
    localparam logic [3:0] REG_IRQ_MASK_RESET = 4'h0;

endpackage

// file: verilog/charger_pulse_program_ctrl.sv
// Pulse-programmed enable, current selection and status for a Li+ charger.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

// Functional notes
// - Enable/program pin is active low; low enables charging, high stops it.
// - Pin held high longer than 4 ms shuts the charger control down.
// - Floating pin reads low by pulldown, giving enabled 400 mA default.
// - High pulses then >4 ms low: one resistor, two 90 mA, three RF test.
// - Four or more pulses select 90 mA.
// - Selection locks once a 4 ms low follows the pulses.
// - Once locked, pulses are ignored until disable or power cycle.
// - With no pulses the default stays selected and unlocked indefinitely.
// - Charging starts 2 ms after power becomes valid with pin low.
// - Pin high during power-up means no charging starts.
// - Current ramps gradually; zero to full takes about 250 us.
// - Status output low in prequal/fast charge, released in top-off or off.
// - Reaching top-off threshold releases status output and latches it.
// - Top-off latch clears on disable, power cycle, or current above hyst.
// - Power-good low when input valid and headroom ok, released otherwise.
// - Battery connection is high impedance whenever charger is disabled.
// - Power-good keeps reporting while the charger is disabled.
module charger_pulse_program_ctrl
    import chg_ctrl_pkg::*;
#(
    parameter int unsigned LOCK_CNT = chg_ctrl_pkg::LOCK_CYCLES,
    parameter int unsigned SHUTDOWN_CNT = chg_ctrl_pkg::SHUTDOWN_CYCLES,
    parameter int unsigned DEBOUNCE_CNT = chg_ctrl_pkg::DEBOUNCE_CYCLES,
    parameter int unsigned RAMP_CNT = chg_ctrl_pkg::RAMP_CYCLES
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Enable/program pin, already resolved with its pulldown.
    input wire logic i_enable_program_n,
    // Analog comparator results.
    input wire logic i_above_undervoltage_limit,
    input wire logic i_below_overvoltage_limit,
    input wire logic i_headroom_250mv,
    input wire logic i_headroom_100mv,
    input wire logic i_topoff_reached,
    input wire logic i_above_topoff_hyst,
    // Register port.
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Charger controls and status pins.
    output logic o_charge_enable,
    output chg_ctrl_pkg::current_sel_t o_current_sel,
    output logic [chg_ctrl_pkg::LEVEL_W-1:0] o_current_level,
    output logic o_battery_pin_oe_n,
    output logic o_charge_status_output_oe_n,
    output logic o_power_good_output_oe_n,
    output logic o_irq
);
    import chg_ctrl_pkg::*;

    // Counters must fit the shared timer and ramp must be nonzero.
    initial begin
        if (LOCK_CNT < 1 || SHUTDOWN_CNT < 1 || DEBOUNCE_CNT < 1 ||
            RAMP_CNT < 1 || LOCK_CNT >= (1 << 24) ||
            SHUTDOWN_CNT >= (1 << 24) || DEBOUNCE_CNT >= (1 << 24)) begin
            $error("charger_pulse_program_ctrl: bad timing parameter");
        end
    end

    localparam int unsigned STEP_DIV = (RAMP_CNT + 254) / 255;

    ////////////////////////////////////////////////////////////////////////////

    // Two-flop synchronisers for all pin and comparator inputs.
    logic [6:0] sync_a;
    logic [6:0] sync_b;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            // Pulldown idle level, so no false pin edge follows reset.
            sync_a <= 7'h00;
            sync_b <= 7'h00;
        end else begin
            sync_a <= {i_above_topoff_hyst, i_topoff_reached,
                       i_headroom_100mv, i_headroom_250mv,
                       i_below_overvoltage_limit,
                       i_above_undervoltage_limit, i_enable_program_n};
            sync_b <= sync_a;
        end
    end

    logic pin_high;
    logic window_ok;
    logic head250;
    logic head100;
    logic topoff_hit;
    logic topoff_clr;
    assign pin_high = sync_b[0]; // Low means enable.
    assign window_ok = sync_b[1] && sync_b[2];
    assign head100 = sync_b[3] ? 1'b1 : sync_b[4];
    assign head250 = sync_b[3];
    assign topoff_hit = sync_b[5];
    assign topoff_clr = sync_b[6];

    ////////////////////////////////////////////////////////////////////////////

    // Power-good follows the input comparators regardless of enable.
    // Hysteresis: once good, it holds until headroom drops under 100 mV or the input leaves the voltage window.
    logic power_good;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            power_good <= 1'b0;
        end else if (!window_ok || !head100) begin
            power_good <= 1'b0;
        end else if (head250) begin
            power_good <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Timebase for pin widths; restarts on every pin edge.
    logic pin_prev;
    logic [23:0] width_cnt;
    logic edge_seen;
    assign edge_seen = pin_prev != pin_high;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_prev <= 1'b0;
            width_cnt <= 24'h000000;
        end else begin
            pin_prev <= pin_high;
            if (edge_seen) begin
                width_cnt <= 24'h000000;
            end else if (width_cnt != 24'hffffff) begin
                width_cnt <= width_cnt + 24'h000001;
            end
        end
    end

    logic long_high;
    logic lock_low;
    assign long_high = pin_high && !edge_seen &&
                       width_cnt >= 24'(SHUTDOWN_CNT - 1);
    assign lock_low = !pin_high && !edge_seen &&
                      width_cnt >= 24'(LOCK_CNT - 1);

    ////////////////////////////////////////////////////////////////////////////

    // Charger state machine.
    chg_state_t state;
    logic [23:0] deb_cnt;
    logic disabled_evt;
    logic pwr_fail_evt;
    assign pwr_fail_evt = !power_good && state != ST_OFF;
    assign disabled_evt = long_high && state != ST_OFF;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= ST_OFF;
            deb_cnt <= 24'h000000;
        end else begin
            case (state)
                ST_OFF: begin
                    deb_cnt <= 24'h000000;
                    // High pin at power-up blocks the start.
                    if (power_good && !pin_high) begin
                        state <= ST_DEBOUNCE;
                    end
                end
                ST_DEBOUNCE: begin
                    if (!power_good || pin_high) begin
                        state <= ST_OFF;
                    end else if (deb_cnt >= 24'(DEBOUNCE_CNT - 1)) begin
                        state <= ST_CHARGE;
                    end else begin
                        deb_cnt <= deb_cnt + 24'h000001;
                    end
                end
                ST_CHARGE: begin
                    if (!power_good || long_high) begin
                        state <= ST_OFF;
                    end else if (topoff_hit) begin
                        state <= ST_TOPOFF;
                    end
                end
                ST_TOPOFF: begin
                    if (!power_good || long_high) begin
                        state <= ST_OFF;
                    end else if (topoff_clr) begin
                        state <= ST_CHARGE;
                    end
                end
                default: begin
                    state <= ST_OFF;
                end
            endcase
        end
    end

    logic active;
    assign active = state == ST_CHARGE || state == ST_TOPOFF;

    ////////////////////////////////////////////////////////////////////////////

    // Pulse counting and lock. A short high (under the shutdown time) that
    // ends counts as one pulse; pulses arriving once locked are ignored.
    logic [PCNT_W-1:0] pulse_cnt;
    logic locked;
    current_sel_t sel;
    logic lock_evt;
    assign lock_evt = !locked && lock_low && pulse_cnt != '0 && active;

    function automatic current_sel_t decode_pulses(
        input logic [PCNT_W-1:0] n
    );
        case (n)
            3'h1: decode_pulses = SEL_RESISTOR;
            3'h2: decode_pulses = SEL_LOW_90;
            3'h3: decode_pulses = SEL_RF_TEST;
            default: decode_pulses = SEL_LOW_90;
        endcase
    endfunction

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pulse_cnt <= '0;
            locked <= 1'b0;
            sel <= SEL_DEFAULT_400;
        end else if (!active) begin
            pulse_cnt <= '0;
            locked <= 1'b0;
            sel <= SEL_DEFAULT_400;
        end else if (!locked) begin
            // Falling edge after a short high closes one pulse.
            if (edge_seen && !pin_high && pulse_cnt != PCNT_SAT) begin
                pulse_cnt <= pulse_cnt + 3'h1;
            end
            if (lock_evt) begin
                locked <= 1'b1;
                sel <= decode_pulses(pulse_cnt);
            end
            // No pulses: stay default and unlocked.
        end
        // Locked: counting stops until disable or power loss.
    end

    ////////////////////////////////////////////////////////////////////////////

    // Soft-start ramp toward full level while charging; restarts from zero
    // when the selection changes so the new current comes up gradually.
    logic [LEVEL_W-1:0] level;
    logic [15:0] step_cnt;
    current_sel_t sel_prev;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            level <= '0;
            step_cnt <= 16'h0000;
            sel_prev <= SEL_DEFAULT_400;
        end else begin
            sel_prev <= sel;
            if (state != ST_CHARGE && state != ST_TOPOFF) begin
                level <= '0;
                step_cnt <= 16'h0000;
            end else if (sel != sel_prev) begin
                level <= '0;
                step_cnt <= 16'h0000;
            end else if (level != LEVEL_FULL) begin
                if (step_cnt >= 16'(STEP_DIV - 1)) begin
                    step_cnt <= 16'h0000;
                    level <= level + 8'h01;
                end else begin
                    step_cnt <= step_cnt + 16'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Interrupts: sticky status, write one to clear, set wins over clear.
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_set;
    logic status_wr;
    assign irq_set = {pwr_fail_evt, disabled_evt,
                      state == ST_CHARGE && topoff_hit, lock_evt};
    assign status_wr = i_wr && i_addr == REG_IRQ_STATUS;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status &
                           ~(status_wr ? i_wdata[IRQ_W-1:0] : '0)) |
                          irq_set;
        end
    end

    // Mask register: a one lets the matching status bit raise the line.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_mask <= REG_IRQ_MASK_RESET;
        end else if (i_wr && i_addr == REG_IRQ_MASK) begin
            irq_mask <= i_wdata[IRQ_W-1:0];
        end
    end

    // Register read data, valid only the cycle after the read strobe.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            case (i_addr)
                REG_STATUS: o_rdata <= {20'h00000, level, sel, locked,
                                        power_good};
                REG_IRQ_STATUS: o_rdata <= {28'h0000000, irq_status};
                REG_IRQ_MASK: o_rdata <= {28'h0000000, irq_mask};
                default: o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Registered outputs. Open-drain enables are low while pulling low.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_charge_enable <= 1'b0;
            o_current_sel <= SEL_DEFAULT_400;
            o_current_level <= '0;
            o_battery_pin_oe_n <= 1'b1;
            o_charge_status_output_oe_n <= 1'b1;
            o_power_good_output_oe_n <= 1'b1;
            o_irq <= 1'b0;
        end else begin
            o_charge_enable <= active;
            o_current_sel <= sel;
            o_current_level <= level;
            o_battery_pin_oe_n <= !active;
            o_charge_status_output_oe_n <= state != ST_CHARGE;
            o_power_good_output_oe_n <= !power_good;
            o_irq <= |(irq_status & irq_mask);
        end
    end

endmodule

// file: test/host_pin_model.sv
// Host model that drives the charger's enable/program pin.
`timescale 1ns/1ps
module host_pin_model (
    // Clock.
    input wire logic i_ref_clk,
    // Resolved pin level seen by the charger.
    output logic o_pin_n
);
    logic drive = 1'b0;
    logic level = 1'b0;

    // An undriven pin falls to the pulldown level, so floating enables.
    assign o_pin_n = drive ? level : 1'b0;

    // Hold one level for n cycles; high means stop, low means run.
    task automatic hold(input logic v, input int n);
        drive <= 1'b1;
        level <= v;
        repeat (n) @(posedge i_ref_clk);
    endtask

    // Send n short high pulses, then the long low that locks them.
    task automatic send_program(input int n, input int w, input int lk);
        for (int k = 0; k < n; k++) begin
            hold(1'b1, w);
            hold(1'b0, w);
        end
        hold(1'b0, lk);
    endtask
endmodule

// file: test/charger_pulse_program_ctrl_properties.sv
// Port-level assertions for the charger pulse-program control block.
`timescale 1ns/1ps
module charger_pulse_program_ctrl_checker
    import chg_ctrl_pkg::*;
#(
    parameter int unsigned SHUTDOWN_CNT = chg_ctrl_pkg::SHUTDOWN_CYCLES
) (
    // Clock, reset and pin.
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_enable_program_n,
    // Comparators and register port.
    input wire logic i_above_undervoltage_limit,
    input wire logic i_below_overvoltage_limit,
    input wire logic i_headroom_250mv,
    input wire logic i_topoff_reached,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // Charger outputs.
    input wire logic o_charge_enable,
    input wire chg_ctrl_pkg::current_sel_t o_current_sel,
    input wire logic o_battery_pin_oe_n,
    input wire logic o_charge_status_output_oe_n,
    input wire logic o_power_good_output_oe_n
);
    int unsigned high_cnt;

    // Counts a high pin; the margin covers synchroniser and output delay.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            high_cnt <= 0;
        end else if (!i_enable_program_n) begin
            high_cnt <= 0;
        end else if (high_cnt < SHUTDOWN_CNT + 10) begin
            high_cnt <= high_cnt + 1;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    ////////////////////////////////////////////////////////////////////////
    chk_bat_when_off: assert property (
        !o_charge_enable && !$past(o_charge_enable) |-> o_battery_pin_oe_n)
        else $error("battery pin connected while charger off");
    chk_status_when_off: assert property (
        !o_charge_status_output_oe_n |->
        o_charge_enable || $past(o_charge_enable))
        else $error("status pulled low while charger off");
    chk_rdata_idle: assert property (
        !$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    chk_long_high_off: assert property (
        high_cnt == SHUTDOWN_CNT + 10 |-> !o_charge_enable &&
        o_battery_pin_oe_n && o_current_sel == SEL_DEFAULT_400)
        else $error("long high did not shut down and reset");
    chk_start_needs: assert property (
        $rose(o_charge_enable) |-> !$past(i_enable_program_n, 2) &&
        !$past(o_power_good_output_oe_n, 10))
        else $error("charging began without low pin and debounce");
    chk_sel_after_low: assert property (
        $changed(o_current_sel) && o_current_sel != SEL_DEFAULT_400 |->
        !$past(i_enable_program_n, 30))
        else $error("selection changed without a long low");
    chk_sel_held: assert property (
        o_charge_enable && $past(o_charge_enable) &&
        $past(o_current_sel) != SEL_DEFAULT_400 |-> $stable(o_current_sel))
        else $error("locked selection changed while charging");
    chk_pok_drop: assert property (
        !i_above_undervoltage_limit [*4] |=> o_power_good_output_oe_n)
        else $error("power good kept low under undervoltage");
    chk_pok_set: assert property (
        (i_above_undervoltage_limit && i_below_overvoltage_limit &&
        i_headroom_250mv) [*5] |=> !o_power_good_output_oe_n)
        else $error("power good not reported on valid input");
    chk_topoff_release: assert property (
        o_charge_enable && i_topoff_reached [*4] |=>
        o_charge_status_output_oe_n)
        else $error("status not released at top-off");

    // Main scenarios reached.
    cover property (o_current_sel == SEL_RF_TEST);
    cover property ($fell(o_charge_enable));
    cover property ($rose(o_charge_status_output_oe_n) && o_charge_enable);
endmodule

bind charger_pulse_program_ctrl charger_pulse_program_ctrl_checker
    #(.SHUTDOWN_CNT(SHUTDOWN_CNT)) checker_inst (.i_ref_clk, .i_arst_n,
    .i_enable_program_n, .i_above_undervoltage_limit,
    .i_below_overvoltage_limit, .i_headroom_250mv, .i_topoff_reached,
    .i_rd, .o_rdata, .o_charge_enable, .o_current_sel,
    .o_battery_pin_oe_n, .o_charge_status_output_oe_n,
    .o_power_good_output_oe_n);

// file: test/test_charger_pulse_program_ctrl.sv
// Self-checking bench for the charger pulse-program control block.
`timescale 1ns/1ps
module test_charger_pulse_program_ctrl;
    import chg_ctrl_pkg::*;
    localparam int LK = 40;
    localparam int SD = 40;
    localparam int DB = 20;
    localparam int RP = 255;
    logic i_ref_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic pin_n;
    logic i_above_undervoltage_limit = 1'b0;
    logic i_below_overvoltage_limit = 1'b1;
    logic i_headroom_250mv = 1'b0;
    logic i_headroom_100mv = 1'b0;
    logic i_topoff_reached = 1'b0;
    logic i_above_topoff_hyst = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic o_charge_enable, o_battery_pin_oe_n, o_irq;
    logic o_charge_status_output_oe_n, o_power_good_output_oe_n;
    current_sel_t o_current_sel;
    logic [LEVEL_W-1:0] o_current_level;
    logic [31:0] lfsr = 32'h00011446;
    int err_count = 0;
    int samples_checked = 0;

    // Short counts keep the run brief; expectations derive from them.
    charger_pulse_program_ctrl #(.LOCK_CNT(LK), .SHUTDOWN_CNT(SD),
        .DEBOUNCE_CNT(DB), .RAMP_CNT(RP)) charger_pulse_program_ctrl_inst (
        .i_ref_clk, .i_arst_n, .i_enable_program_n(pin_n),
        .i_above_undervoltage_limit, .i_below_overvoltage_limit,
        .i_headroom_250mv, .i_headroom_100mv, .i_topoff_reached,
        .i_above_topoff_hyst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .o_charge_enable, .o_current_sel, .o_current_level,
        .o_battery_pin_oe_n, .o_charge_status_output_oe_n,
        .o_power_good_output_oe_n, .o_irq);
    host_pin_model host_pin_model_inst (.i_ref_clk, .o_pin_n(pin_n));

    // Clock at 100 MHz.
    always #5 i_ref_clk = ~i_ref_clk;

    ////////////////////////////////////////////////////////////////////////
    function automatic int pick(input int span);
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return int'(lfsr[15:0]) % span;
    endfunction
    function automatic current_sel_t exp_sel(input int n);
        if (n == 1) return SEL_RESISTOR;
        if (n == 3) return SEL_RF_TEST;
        return SEL_LOW_90;
    endfunction
    task automatic check(input string w, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask
    // Waits past the edge so registered outputs have settled.
    task automatic cy(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rchk(input string w, input logic [3:0] a,
        input logic [31:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        check(w, e, o_rdata);
        @(posedge i_ref_clk);
        #1;
    endtask
    task automatic power(input logic v);
        i_above_undervoltage_limit <= v;
        i_headroom_250mv <= v;
        i_headroom_100mv <= v;
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog cuts a hang short.
    initial begin
        #600000;
        err_count++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        cy(10);
        i_arst_n <= 1'b1;
        rchk("mask", REG_IRQ_MASK, 32'h0);
        rchk("unmapped", 4'hc, 32'h0);
        power(1'b1);
        cy(8);
        check("pok", 1'b0, o_power_good_output_oe_n);
        check("early", 1'b0, o_charge_enable);
        cy(DB + 10);
        check("start", 1'b1, o_charge_enable);
        check("chg", 1'b0, o_charge_status_output_oe_n);
        check("bat", 1'b0, o_battery_pin_oe_n);
        cy(RP + 100);
        rchk("status", REG_STATUS, 32'h00000ff1);
        wr(REG_IRQ_MASK, 32'h1);
        for (int n = 1; n <= 5; n++) begin
            wr(REG_IRQ_STATUS, 32'hf);
            host_pin_model_inst.send_program(n, 5 + pick(30), LK + 20);
            cy(1);
            check("sel", exp_sel(n), o_current_sel);
            check("irq", 1'b1, o_irq);
            check("ramp", 1'b1, o_current_level < LEVEL_FULL);
            cy(RP + 20);
            check("full", LEVEL_FULL, o_current_level);
            host_pin_model_inst.send_program(1, 10, LK + 20);
            cy(1);
            check("held", exp_sel(n), o_current_sel);
            host_pin_model_inst.hold(1'b1, SD + 20);
            cy(1);
            check("off", 1'b0, o_charge_enable);
            check("bat off", 1'b1, o_battery_pin_oe_n);
            check("chg off", 1'b1, o_charge_status_output_oe_n);
            check("sel off", SEL_DEFAULT_400, o_current_sel);
            check("pok off", 1'b0, o_power_good_output_oe_n);
            host_pin_model_inst.hold(1'b0, DB + 20);
            cy(1);
            check("on", 1'b1, o_charge_enable);
        end
        rchk("irq st", REG_IRQ_STATUS, 32'h5);
        wr(REG_IRQ_MASK, 32'h0);
        cy(2);
        check("masked", 1'b0, o_irq);
        wr(REG_IRQ_MASK, 32'h4);
        cy(2);
        check("irq dis", 1'b1, o_irq);
        wr(REG_IRQ_STATUS, 32'h5);
        cy(2);
        check("cleared", 1'b0, o_irq);
        // Top-off latch holds until hysteresis, then until re-enable.
        i_topoff_reached <= 1'b1;
        cy(8);
        check("topoff", 1'b1, o_charge_status_output_oe_n);
        i_topoff_reached <= 1'b0;
        cy(8);
        check("latched", 1'b1, o_charge_status_output_oe_n);
        i_above_topoff_hyst <= 1'b1;
        cy(8);
        check("hyst", 1'b0, o_charge_status_output_oe_n);
        i_above_topoff_hyst <= 1'b0;
        i_topoff_reached <= 1'b1;
        cy(8);
        i_topoff_reached <= 1'b0;
        host_pin_model_inst.hold(1'b1, SD + 20);
        host_pin_model_inst.hold(1'b0, DB + 20);
        cy(1);
        check("reen", 1'b0, o_charge_status_output_oe_n);
        // Power loss drops the selection; pin high at power-up blocks start.
        host_pin_model_inst.send_program(3, 12, LK + 20);
        i_below_overvoltage_limit <= 1'b0;
        cy(8);
        check("ovp", 1'b1, o_power_good_output_oe_n);
        i_below_overvoltage_limit <= 1'b1;
        power(1'b0);
        cy(10);
        check("lost", 1'b0, o_charge_enable);
        check("lost sel", SEL_DEFAULT_400, o_current_sel);
        host_pin_model_inst.hold(1'b1, 2);
        power(1'b1);
        cy(DB + 40);
        check("held off", 1'b0, o_charge_enable);
        host_pin_model_inst.hold(1'b0, DB + 20);
        cy(1);
        check("late on", 1'b1, o_charge_enable);
        tally_and_finish();
    end
endmodule
